/* src/can_bit_timing_map.vh */
// register offsets, field positions, reset values and timing counts for the
// can bit timing and mask select block; included by its bare name
//
// Function
// - wake filter bit routes line through filter
// - phase segment 2 length is field plus one when bit 7 set, else greater of segment 1 and processing time
// - sample bit selects three samples or one
// - propagation segment length is field plus one
// - mask code selects mask 0, 1, 2
// - filters 15..8 in one register, paired bits
`ifndef CAN_BIT_TIMING_MAP_VH
`define CAN_BIT_TIMING_MAP_VH

// register word offsets on the register port
`define CAN_BIT_TIMING_CONFIG_OFS 4'h0
`define FILTER_MASK_SELECT_UPPER_OFS 4'h1

// can_bit_timing_config field positions
`define WAKE_LINE_FILTER_SEL_BIT 14
`define PHASE_SEG2_LEN_HI 10
`define PHASE_SEG2_LEN_LO 8
`define PHASE_SEG2_FREE_PROG_BIT 7
`define TRIPLE_SAMPLE_SEL_BIT 6
`define PHASE_SEG1_LEN_HI 5
`define PHASE_SEG1_LEN_LO 3
`define PROP_SEG_LEN_HI 2
`define PROP_SEG_LEN_LO 0
`define CAN_BIT_TIMING_CONFIG_WMASK 16'h47ff

// reset values
`define CAN_BIT_TIMING_CONFIG_RST 16'h0000
`define FILTER_MASK_SELECT_UPPER_RST 16'h0000

// mask source codes
`define MASK_SRC_0 2'h0
`define MASK_SRC_1 2'h1
`define MASK_SRC_2 2'h2
`define MASK_SRC_RSVD 2'h3
`define FIRST_UPPER_FILTER 4'h8

// timing
`define CLK_PERIOD_NS 5
`define TQ_DIV 8'h0a
`define PROCESSING_TIME_TQ 4'h2
`define LINE_FILT_NS 50
`define LINE_FILT_CYC ((`LINE_FILT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LINE_FILT_LAST 5'h09

`endif

/* src/can_bit_timing_mask_select.v */
// can bit timing, sampling, wake line filter and upper filter mask select
// assumes a 200 MHz clock, a synchronous active low reset and a register
// port master that never issues read and write strobes together
`timescale 1ns/1ps
`default_nettype none
`include "can_bit_timing_map.vh"

module can_bit_timing_mask_select (
   // clock and reset
   input wire mclk_in,
   input wire rst_b_in,
   // register port
   input wire [3:0] addr_in,
   input wire [15:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output reg [15:0] rdata_out,
   // can receive line and its results
   input wire can_rx_in,
   output reg wake_out,
   output reg sample_strobe_out,
   output reg sampled_bit_out,
   // segment lengths in time quanta
   output reg [3:0] prop_seg_tq_out,
   output reg [3:0] phase_seg1_tq_out,
   output reg [3:0] phase_seg2_tq_out,
   // mask lookup for a receive filter
   input wire [3:0] filter_idx_in,
   output reg [1:0] mask_sel_out,
   output reg mask_valid_out
);

   // a three bit length code gives code plus one quanta
   function [3:0] seg_len;
      input [2:0] code;
      begin
         seg_len = {1'b0, code} + 4'h1;
      end
   endfunction

   // true when the address hits the given register offset
   function addr_hit;
      input [3:0] addr;
      input [3:0] ofs;
      begin
         addr_hit = (addr == ofs);
      end
   endfunction
   reg [15:0] bit_timing_reg;
   reg [15:0] mask_select_reg;
   reg rx_s1_reg;
   reg rx_s2_reg;
   reg rx_s3_reg;
   reg rx_line_reg;
   reg rx_line_d_reg;
   reg filt_line_reg;
   reg [4:0] filt_cnt_reg;
   reg wake_line_d_reg;
   reg [7:0] tq_div_reg;
   reg [4:0] tq_cnt_reg;
   reg smp0_reg;
   reg smp1_reg;
   wire [3:0] prop_len;
   wire [3:0] ps1_len;
   wire [3:0] ps2_len;
   wire [4:0] sample_pt;
   wire [4:0] bit_len;
   wire tq_tick;
   wire hard_sync;
   wire wake_line;
   wire [15:0] rd_mux;
   wire [15:0] mask_rsvd;
   wire [31:0] mask_codes;

   // segment lengths decoded from the timing register
   assign prop_len = seg_len(bit_timing_reg[`PROP_SEG_LEN_HI:`PROP_SEG_LEN_LO]);
   assign ps1_len = seg_len(bit_timing_reg[`PHASE_SEG1_LEN_HI:`PHASE_SEG1_LEN_LO]);
   // free programmed or the greater of segment 1 and processing time
   assign ps2_len = bit_timing_reg[`PHASE_SEG2_FREE_PROG_BIT] ?
      seg_len(bit_timing_reg[`PHASE_SEG2_LEN_HI:`PHASE_SEG2_LEN_LO]) :
      ((ps1_len > `PROCESSING_TIME_TQ) ? ps1_len : `PROCESSING_TIME_TQ);
   assign sample_pt = 5'h01 + {1'b0, prop_len} + {1'b0, ps1_len};
   assign bit_len = sample_pt + {1'b0, ps2_len};

   // register writes; reserved bits stay zero
   always @(posedge mclk_in)
   begin
      if (!rst_b_in)
      begin
         bit_timing_reg <= `CAN_BIT_TIMING_CONFIG_RST;
         mask_select_reg <= `FILTER_MASK_SELECT_UPPER_RST;
      end
      else if (wr_in)
      begin
         if (addr_hit(addr_in, `CAN_BIT_TIMING_CONFIG_OFS))
         begin
            bit_timing_reg <= wdata_in & `CAN_BIT_TIMING_CONFIG_WMASK;
         end
         if (addr_hit(addr_in, `FILTER_MASK_SELECT_UPPER_OFS))
         begin
            mask_select_reg <= wdata_in;
         end
      end
   end

   // read mux; unmapped offsets read zero
   assign rd_mux = addr_hit(addr_in, `CAN_BIT_TIMING_CONFIG_OFS) ? bit_timing_reg :
      addr_hit(addr_in, `FILTER_MASK_SELECT_UPPER_OFS) ? mask_select_reg : 16'h0000;

   // read data stand only in the cycle after the strobe
   always @(posedge mclk_in)
   begin
      if (!rst_b_in)
      begin
         rdata_out <= 16'h0000;
      end
      else
      begin
         rdata_out <= rd_in ? rd_mux : 16'h0000;
      end
   end

   // per filter code slices, filter 8 in the low pair, 15 in the high pair
   genvar k;
   generate
      for (k = 0; k < 8; k = k + 1)
      begin : g_filt
         assign mask_codes[4*k+3:4*k] = {2'h0, mask_select_reg[2*k+1:2*k]};
         assign mask_rsvd[2*k+1:2*k] = {1'b0, mask_select_reg[2*k+1:2*k] == `MASK_SRC_RSVD};
      end
   endgenerate

   // mask lookup for the requested filter; reserved code falls back to mask 0
   always @(posedge mclk_in)
   begin
      if (!rst_b_in)
      begin
         mask_sel_out <= `MASK_SRC_0;
         mask_valid_out <= 1'b0;
      end
      else if (filter_idx_in[3])
      begin
         mask_valid_out <= ~mask_rsvd[{filter_idx_in[2:0], 1'b0}];
         case (mask_codes[{filter_idx_in[2:0], 2'h0} +: 2])
            `MASK_SRC_1: mask_sel_out <= `MASK_SRC_1;
            `MASK_SRC_2: mask_sel_out <= `MASK_SRC_2;
            default: mask_sel_out <= `MASK_SRC_0;
         endcase
      end
      else
      begin
         mask_sel_out <= `MASK_SRC_0;
         mask_valid_out <= 1'b0;
      end
   end

   // three flop synchroniser; the line moves once stages two and three agree
   always @(posedge mclk_in)
   begin
      if (!rst_b_in)
      begin
         rx_s1_reg <= 1'b1;
         rx_s2_reg <= 1'b1;
         rx_s3_reg <= 1'b1;
         rx_line_reg <= 1'b1;
         rx_line_d_reg <= 1'b1;
      end
      else
      begin
         rx_s1_reg <= can_rx_in;
         rx_s2_reg <= rx_s1_reg;
         rx_s3_reg <= rx_s2_reg;
         if (rx_s2_reg == rx_s3_reg)
         begin
            rx_line_reg <= rx_s3_reg;
         end
         rx_line_d_reg <= rx_line_reg;
      end
   end

   // line filter: a level must hold for the filter time to pass
   always @(posedge mclk_in)
   begin
      if (!rst_b_in)
      begin
         filt_line_reg <= 1'b1;
         filt_cnt_reg <= 5'h00;
      end
      else if (rx_line_reg == filt_line_reg)
      begin
         filt_cnt_reg <= 5'h00;
      end
      else if (filt_cnt_reg == `LINE_FILT_LAST)
      begin
         filt_line_reg <= rx_line_reg;
         filt_cnt_reg <= 5'h00;
      end
      else
      begin
         filt_cnt_reg <= filt_cnt_reg + 5'h01;
      end
   end

   // wake detection on a dominant edge of the filtered or raw line
   assign wake_line = bit_timing_reg[`WAKE_LINE_FILTER_SEL_BIT] ?
      filt_line_reg : rx_line_reg;
   always @(posedge mclk_in)
   begin
      if (!rst_b_in)
      begin
         wake_line_d_reg <= 1'b1;
         wake_out <= 1'b0;
      end
      else
      begin
         wake_line_d_reg <= wake_line;
         wake_out <= wake_line_d_reg & ~wake_line;
      end
   end

   // time quantum divider and bit position counter, hard sync on dominant edge
   assign hard_sync = rx_line_d_reg & ~rx_line_reg;
   assign tq_tick = (tq_div_reg == `TQ_DIV - 8'h01);
   always @(posedge mclk_in)
   begin
      if (!rst_b_in || hard_sync)
      begin
         tq_div_reg <= 8'h00;
         tq_cnt_reg <= 5'h00;
      end
      else if (tq_tick)
      begin
         tq_div_reg <= 8'h00;
         tq_cnt_reg <= (tq_cnt_reg == bit_len - 5'h01) ? 5'h00 : tq_cnt_reg + 5'h01;
      end
      else
      begin
         tq_div_reg <= tq_div_reg + 8'h01;
      end
   end

   // sampling: once at the sample point, or majority of the last three quanta
   always @(posedge mclk_in)
   begin
      if (!rst_b_in)
      begin
         smp0_reg <= 1'b1;
         smp1_reg <= 1'b1;
         sample_strobe_out <= 1'b0;
         sampled_bit_out <= 1'b1;
      end
      else
      begin
         sample_strobe_out <= 1'b0;
         if (tq_tick && !hard_sync)
         begin
            if (tq_cnt_reg == sample_pt - 5'h03)
            begin
               smp0_reg <= rx_line_reg;
            end
            if (tq_cnt_reg == sample_pt - 5'h02)
            begin
               smp1_reg <= rx_line_reg;
            end
            if (tq_cnt_reg == sample_pt - 5'h01)
            begin
               sample_strobe_out <= 1'b1;
               if (bit_timing_reg[`TRIPLE_SAMPLE_SEL_BIT])
               begin
                  sampled_bit_out <= (smp0_reg & smp1_reg) | (smp0_reg & rx_line_reg) |
                     (smp1_reg & rx_line_reg);
               end
               else
               begin
                  sampled_bit_out <= rx_line_reg;
               end
            end
         end
      end
   end

   // registered segment lengths for the bit engine
   always @(posedge mclk_in)
   begin
      if (!rst_b_in)
      begin
         prop_seg_tq_out <= 4'h1;
         phase_seg1_tq_out <= 4'h1;
         phase_seg2_tq_out <= `PROCESSING_TIME_TQ;
      end
      else
      begin
         prop_seg_tq_out <= prop_len;
         phase_seg1_tq_out <= ps1_len;
         phase_seg2_tq_out <= ps2_len;
      end
   end
endmodule
`default_nettype wire

/* tb/can_bit_timing_checker.sv */
// checker for the bit timing and upper mask select block
// sees only the top ports; bound to the block after the module
`timescale 1ns/1ps
`default_nettype none
module can_bit_timing_checker (
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic [3:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [15:0] rdata_out,
   input wire logic can_rx_in,
   input wire logic wake_out,
   input wire logic sample_strobe_out,
   input wire logic sampled_bit_out,
   input wire logic [3:0] prop_seg_tq_out,
   input wire logic [3:0] phase_seg1_tq_out,
   input wire logic [3:0] phase_seg2_tq_out,
   input wire logic [3:0] filter_idx_in,
   input wire logic [1:0] mask_sel_out,
   input wire logic mask_valid_out
);
   logic [15:0] msk_reg;
   logic wfil_reg;
   logic [4:0] low_reg;
   wire [1:0] code = msk_reg[{filter_idx_in[2:0], 1'b0} +: 2];
   // shadow of written fields and run length of a dominant line
   always @(posedge mclk_in)
   begin
      if (!rst_b_in)
      begin
         msk_reg <= 16'h0;
         wfil_reg <= 1'b0;
      end
      else if (wr_in && addr_in == 4'h1)
         msk_reg <= wdata_in;
      else if (wr_in && addr_in == 4'h0)
         wfil_reg <= wdata_in[14];
      low_reg <= can_rx_in ? 5'h0 : (low_reg == 5'h1f ? low_reg : low_reg + 5'h1);
   end
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);
   // a timing write followed by a quiet cycle
   sequence s_cfg;
      wr_in && addr_in == 4'h0 ##1 !(wr_in && addr_in == 4'h0);
   endsequence
   AST_PROP: assert property (s_cfg |=>
      prop_seg_tq_out == $past(wdata_in[2:0], 2) + 4'h1) else $error("prop length wrong");
   AST_SEG1: assert property (s_cfg |=>
      phase_seg1_tq_out == $past(wdata_in[5:3], 2) + 4'h1) else $error("seg1 length wrong");
   AST_SEG2: assert property (s_cfg |=> phase_seg2_tq_out == ($past(wdata_in[7], 2) ?
      $past(wdata_in[10:8], 2) + 4'h1 : ($past(wdata_in[5:3], 2) != 3'h0 ?
      $past(wdata_in[5:3], 2) + 4'h1 : 4'h2))) else $error("seg2 length wrong");
   AST_MASK: assert property (filter_idx_in[3] && $stable(filter_idx_in) &&
      $stable(msk_reg) |=> mask_sel_out == ($past(code) == 2'h3 ? 2'h0 : $past(code))
      && mask_valid_out == ($past(code) != 2'h3)) else $error("mask select wrong");
   AST_LOW: assert property (!filter_idx_in[3] |=>
      mask_sel_out == 2'h0 && !mask_valid_out) else $error("lower filter answered");
   AST_RD: assert property (rd_in && addr_in == 4'h1 |=>
      rdata_out == $past(msk_reg)) else $error("mask register read wrong");
   AST_BIT: assert property ($changed(sampled_bit_out) |->
      sample_strobe_out || $past(sample_strobe_out)) else $error("bit moved off sample point");
   AST_WAKE: assert property (wake_out && wfil_reg |->
      low_reg >= 5'h0a) else $error("filtered wake too early");
endmodule
bind can_bit_timing_mask_select can_bit_timing_checker can_bit_timing_checker_inst (
   .mclk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .can_rx_in,
   .wake_out, .sample_strobe_out, .sampled_bit_out, .prop_seg_tq_out, .phase_seg1_tq_out,
   .phase_seg2_tq_out, .filter_idx_in, .mask_sel_out, .mask_valid_out);
`default_nettype wire

/* tb/can_bus_node.sv */
// other nodes on the can bus, seen as one wired line
// recessive high by the pull-up whenever no node pulls it dominant
`timescale 1ns/1ps
`default_nettype none
module can_bus_node (
   // node request
   input wire logic dominant_in,
   // resolved bus line
   output logic can_rx_out
);
   // dominant wins, else the pull-up
   assign can_rx_out = dominant_in ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* tb/can_bit_timing_mask_select_tb.sv */
// self-checking bench for the bit timing and upper mask select block
// assumes the checker is bound in and the bus node model drives the line
`timescale 1ns/1ps
`default_nettype none
module can_bit_timing_mask_select_tb;
   logic mclk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [3:0] addr_in = 4'h0;
   logic [15:0] wdata_in = 16'h0;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [3:0] filter_idx_in = 4'h0;
   logic dom = 1'b0;
   wire can_rx_in;
   wire [15:0] rdata_out;
   wire wake_out, sample_strobe_out, sampled_bit_out, mask_valid_out;
   wire [3:0] prop_seg_tq_out, phase_seg1_tq_out, phase_seg2_tq_out;
   wire [1:0] mask_sel_out;
   int bad_count = 0;
   int checks_done = 0;
   int wakes = 0;
   // clock and wake pulse count
   always #2.5 mclk_in = ~mclk_in;
   always @(posedge mclk_in) if (wake_out === 1'b1) wakes <= wakes + 1;
   can_bus_node can_bus_node_inst (.dominant_in(dom), .can_rx_out(can_rx_in));
   can_bit_timing_mask_select can_bit_timing_mask_select_inst (.mclk_in, .rst_b_in,
      .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .can_rx_in, .wake_out,
      .sample_strobe_out, .sampled_bit_out, .prop_seg_tq_out, .phase_seg1_tq_out,
      .phase_seg2_tq_out, .filter_idx_in, .mask_sel_out, .mask_valid_out);
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge mclk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      @(negedge mclk_in);
      chk(rdata_out, exp);
   endtask
   task automatic t_regs;
      rd(4'h0, 16'h0);
      rd(4'h1, 16'h0);
      wr(4'h0, 16'hffff);
      rd(4'h0, 16'h47ff);
      wr(4'h1, 16'haaaa);
      rd(4'h1, 16'haaaa);
      wr(4'h1, 16'h5555);
      rd(4'h1, 16'h5555);
      wr(4'h2, 16'h1234);
      rd(4'h2, 16'h0);
   endtask
   task automatic t_timing;
      for (int i = 0; i < 8; i++)
      begin
         wr(4'h0, {5'h0, i[2:0], 2'b10, i[2:0], 3'h7 - i[2:0]});
         repeat (2) @(negedge mclk_in);
         chk(prop_seg_tq_out, 16'h8 - i);
         chk(phase_seg1_tq_out, 16'h1 + i);
         chk(phase_seg2_tq_out, 16'h1 + i);
         wr(4'h0, {5'h0, 3'h7, 2'b00, i[2:0], 3'h0});
         repeat (2) @(negedge mclk_in);
         chk(phase_seg2_tq_out, (i < 2) ? 16'h2 : 16'h1 + i);
      end
   endtask
   task automatic t_mask;
      logic [1:0] c;
      wr(4'h1, 16'h2424);
      for (int i = 0; i < 16; i++)
      begin
         c = 2'(16'h2424 >> (2 * (i % 8)));
         @(posedge mclk_in);
         filter_idx_in <= 4'(i);
         repeat (2) @(negedge mclk_in);
         chk(mask_sel_out, (i > 7 && c != 2'h3) ? c : 2'h0);
         chk(mask_valid_out, i > 7 && c != 2'h3);
      end
   endtask
   task automatic t_wake(input logic fil, input int len, input int exp);
      int w0;
      wr(4'h0, {1'b0, fil, 14'h0});
      w0 = wakes;
      @(posedge mclk_in);
      dom <= 1'b1;
      repeat (len) @(posedge mclk_in);
      dom <= 1'b0;
      repeat (30) @(posedge mclk_in);
      chk(16'(wakes - w0), 16'(exp));
   endtask
   task automatic strobe_bit(input logic exp);
      int n;
      n = 0;
      while (sample_strobe_out !== 1'b1 && n < 300)
      begin
         @(negedge mclk_in);
         n++;
      end
      if (n == 300)
      begin
         bad_count++;
         test_done();
      end
      @(negedge mclk_in);
      chk(sampled_bit_out, exp);
   endtask
   task automatic t_sample(input logic tri_sel);
      wr(4'h0, {9'h0, tri_sel, 6'h0});
      @(posedge mclk_in);
      dom <= 1'b1;
      repeat (8) @(posedge mclk_in);
      strobe_bit(1'b0);
      @(posedge mclk_in);
      dom <= 1'b0;
      repeat (8) @(posedge mclk_in);
      strobe_bit(1'b1);
      // dominant through the first two samples only: three samples keep it, one does not
      @(posedge mclk_in);
      dom <= 1'b1;
      repeat (28) @(posedge mclk_in);
      dom <= 1'b0;
      strobe_bit(~tri_sel);
   endtask
   // reset, then the scenarios in turn
   initial
   begin
      repeat (10) @(posedge mclk_in);
      rst_b_in <= 1'b1;
      t_regs();
      t_timing();
      t_mask();
      t_wake(1'b0, 4, 1);
      t_wake(1'b1, 4, 0);
      t_wake(1'b1, 20, 1);
      t_sample(1'b0);
      t_sample(1'b1);
      test_done();
   end
endmodule
`default_nettype wire
